/* core/sbpf_map.vh */
// Constants for the slave board pin-function block
`ifndef SBPF_MAP_VH
`define SBPF_MAP_VH

`define SBPF_CSR3_EE_PINS_BIT   4
`define SBPF_CSR3_EEPROM_RELOAD_BIT_BIT   14
`define SBPF_CSR2_ARCHITECTURE_SELECT_BIT_BIT    13
`define SBPF_LED_OFF            1'b1
`define SBPF_EE_WORDS           8
`define SBPF_EE_ADDR_W          3
`define SBPF_EE_BITS            16
`define SBPF_BIT_LAST           4'hf
`define SBPF_PRDB_EEPROM_DATA_OUT_BIT      2
`define SBPF_SK_DIV             4'h4
`define SBPF_ST_IDLE            2'h0
`define SBPF_ST_SHIFT           2'h1
`define SBPF_ST_DONE            2'h2

`endif

/* core/sbpf_ee_mem.v */
// Small word store for the EEPROM contents shifted in at load
`timescale 1ns/1ps
`default_nettype none
`include "sbpf_map.vh"

module sbpf_ee_mem (
    input  wire                         i_ref_clk,
    input  wire                         i_we,
    input  wire [`SBPF_EE_ADDR_W-1:0]   i_waddr,
    input  wire [`SBPF_EE_BITS-1:0]     i_wdata,
    input  wire [`SBPF_EE_ADDR_W-1:0]   i_raddr,
    output reg  [`SBPF_EE_BITS-1:0]     o_rdata
);

    reg [`SBPF_EE_BITS-1:0] mem [0:`SBPF_EE_WORDS-1];

    always @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule

`default_nettype wire

/* core/sbpf_top.v */
// Pin-function and board-interface control for the slave network controller
// Function
// - Address-detect mode turns indicators 1-3 into delimiter, data, clock.
// - Indicator outputs are active low and software selects their meaning.
// - Config3 bit 4 switches private data bits 2,1,0 to EEPROM pins.
// - Shift-busy asserted only while EEPROM shifts in after reset or reload.
// - Shift-busy pin sampled low forces an EEPROM checksum error.
// - EEPROM chip select on every access and during reset load.
// - Sleep input low resets internally and holds outputs other than o_ee_rdata at reset.
// - Board holds architecture pin low; sampled after reset completes.
// - Config2 bit 13 selects shared memory or programmed I/O.
// - In shared-memory mode, match with read or write strobe is a memory access.
// - Flash boot option makes shared pin SRAM select, else irq 12.
// - Write strobe is SRAM write enable, or global with flash fitted.
// - SRAM output enable is registered from shared-memory match with read strobe.
// - Test data output is high impedance unless shifting.
// - Unconnected test data and mode select read as high.
// - Address-detect reject is internal match OR external reject input.
`timescale 1ns/1ps
`default_nettype none
`include "sbpf_map.vh"

module sbpf_top (
    input  wire         i_ref_clk,
    input  wire         i_rst,
    input  wire         i_sleep_n,
    input  wire [15:0]  i_csr2,
    input  wire [15:0]  i_csr3,
    input  wire         i_ext_addr_detect_mode,
    input  wire         i_flash_boot,
    input  wire         i_flash_fitted,
    input  wire [3:0]   i_led_status,
    input  wire         i_link_status,
    input  wire         i_start_frame_byte_delimiter,
    input  wire         i_serial_receive_data,
    input  wire         i_serial_receive_clock,
    input  wire         i_internal_reject,
    input  wire         i_external_reject_input,
    input  wire         i_shift_busy,
    input  wire         i_ee_sw_cs,
    input  wire         i_ee_sw_sk,
    input  wire         i_ee_sw_di,
    input  wire [7:0]   i_prdb_in,
    input  wire [7:0]   i_prdb_out,
    input  wire         i_prdb_drive,
    input  wire         i_slave_architecture_select,
    input  wire         i_shared_memory_match_n,
    input  wire         i_host_memory_read_strobe_n,
    input  wire         i_host_memory_write_strobe_n,
    input  wire         i_irq12,
    input  wire         i_tap_shifting,
    input  wire         i_tap_tdo,
    input  wire         i_tdi_in,
    input  wire         i_tdi_oe,
    input  wire         i_tms_in,
    input  wire         i_tms_oe,
    input  wire [`SBPF_EE_ADDR_W-1:0] i_ee_raddr,
    output reg  [3:0]   o_indicator_outputs_n,
    output reg          o_frame_reject,
    output reg  [7:0]   o_prdb_out,
    output reg  [7:0]   o_prdb_oe,
    output reg          o_eeprom_chip_select,
    output reg          o_shift_busy_out,
    output reg          o_shift_busy_oe,
    output reg          o_ee_checksum_err,
    output reg          o_eeprom_reload_bit_done,
    output reg          o_bus_slave_mode,
    output reg          o_pio_mode,
    output reg          o_shmem_read,
    output reg          o_shmem_write,
    output reg          o_sram_select_or_irq_line,
    output reg          o_sram_or_global_write_strobe_n,
    output reg          o_sram_output_enable_n,
    output reg          o_tdo,
    output reg          o_tdo_oe,
    output reg          o_tdi_eff,
    output reg          o_tms_eff,
    output wire [`SBPF_EE_BITS-1:0] o_ee_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // Sleep acts as a reset source; while asleep, inputs other than sleep and i_ee_raddr are ignored
    wire int_rst = i_rst | ~i_sleep_n;

    reg  [1:0]  st_ff;
    reg  [1:0]  nxt_st;
    reg  [3:0]  div_ff;
    reg         sk_ff;
    reg  [3:0]  bit_ff;
    reg  [`SBPF_EE_ADDR_W-1:0] word_ff;
    reg  [`SBPF_EE_BITS-1:0]   sh_ff;
    reg         we_ff;
    reg         load_d_ff;
    reg         arch_seen_ff;

    wire ee_pins   = i_csr3[`SBPF_CSR3_EE_PINS_BIT];
    wire load_req  = i_csr3[`SBPF_CSR3_EEPROM_RELOAD_BIT_BIT];
    wire load_rise = load_req & ~load_d_ff;
    wire sk_tick   = (div_ff == `SBPF_SK_DIV);
    wire last_bit  = (bit_ff == `SBPF_BIT_LAST);
    wire last_word = (word_ff == {`SBPF_EE_ADDR_W{1'b1}});
    wire ee_do     = i_prdb_in[`SBPF_PRDB_EEPROM_DATA_OUT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // EEPROM load sequencer
    always @* begin
        nxt_st = st_ff;
        case (st_ff)
            `SBPF_ST_IDLE: begin
                if (load_rise) begin
                    nxt_st = `SBPF_ST_SHIFT;
                end
            end
            `SBPF_ST_SHIFT: begin
                if (sk_tick & sk_ff & last_bit & last_word) begin
                    nxt_st = `SBPF_ST_DONE;
                end
            end
            `SBPF_ST_DONE: nxt_st = `SBPF_ST_IDLE;
            default:       nxt_st = `SBPF_ST_IDLE;
        endcase
    end

    always @(posedge i_ref_clk or posedge int_rst) begin
        if (int_rst) begin
            // Hardware reset starts an automatic load
            st_ff     <= `SBPF_ST_SHIFT;
            div_ff    <= 4'h0;
            sk_ff     <= 1'b0;
            bit_ff    <= 4'h0;
            word_ff   <= {`SBPF_EE_ADDR_W{1'b0}};
            sh_ff     <= {`SBPF_EE_BITS{1'b0}};
            we_ff     <= 1'b0;
            load_d_ff <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            load_d_ff <= load_req;
            we_ff     <= 1'b0;
            if (st_ff == `SBPF_ST_SHIFT) begin
                div_ff <= sk_tick ? 4'h0 : div_ff + 4'h1;
                if (sk_tick) begin
                    sk_ff <= ~sk_ff;
                    if (~sk_ff) begin
                        sh_ff <= {sh_ff[`SBPF_EE_BITS-2:0], ee_do};
                    end else begin
                        bit_ff <= bit_ff + 4'h1;
                        if (last_bit) begin
                            we_ff   <= 1'b1;
                            word_ff <= word_ff + 1'b1;
                        end
                    end
                end
            end else begin
                div_ff  <= 4'h0;
                sk_ff   <= 1'b0;
                bit_ff  <= 4'h0;
                word_ff <= {`SBPF_EE_ADDR_W{1'b0}};
            end
        end
    end

    sbpf_ee_mem u_mem (
        .i_ref_clk (i_ref_clk),
        .i_we      (we_ff),
        .i_waddr   (word_ff - 1'b1),
        .i_wdata   (sh_ff),
        .i_raddr   (i_ee_raddr),
        .o_rdata   (o_ee_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered pin functions; no role changes between edges
    always @(posedge i_ref_clk or posedge int_rst) begin
        if (int_rst) begin
            o_indicator_outputs_n <= {4{`SBPF_LED_OFF}};
            o_frame_reject        <= 1'b0;
            o_prdb_out            <= 8'h00;
            o_prdb_oe             <= 8'h00;
            o_eeprom_chip_select  <= 1'b0;
            o_shift_busy_out      <= 1'b0;
            o_shift_busy_oe       <= 1'b0;
            o_ee_checksum_err     <= 1'b0;
            o_eeprom_reload_bit_done        <= 1'b0;
            o_bus_slave_mode      <= 1'b0;
            o_pio_mode            <= 1'b0;
            o_shmem_read          <= 1'b0;
            o_shmem_write         <= 1'b0;
            o_sram_select_or_irq_line       <= 1'b1;
            o_sram_or_global_write_strobe_n <= 1'b1;
            o_sram_output_enable_n          <= 1'b1;
            o_tdo                 <= 1'b0;
            o_tdo_oe              <= 1'b0;
            o_tdi_eff             <= 1'b1;
            o_tms_eff             <= 1'b1;
            arch_seen_ff          <= 1'b0;
        end else begin
            if (i_ext_addr_detect_mode) begin
                o_indicator_outputs_n <= ~{i_serial_receive_clock,
                                           i_serial_receive_data,
                                           i_start_frame_byte_delimiter,
                                           i_link_status};
                o_frame_reject <= i_internal_reject
                                | i_external_reject_input;
            end else begin
                o_indicator_outputs_n <= ~i_led_status;
                o_frame_reject        <= i_internal_reject;
            end
            if (ee_pins | (st_ff == `SBPF_ST_SHIFT)) begin
                // Bit 2 becomes an input from the EEPROM
                o_prdb_out <= {i_prdb_out[7:3], 1'b0,
                    (st_ff == `SBPF_ST_SHIFT) ? 1'b0 : i_ee_sw_di,
                    (st_ff == `SBPF_ST_SHIFT) ? sk_ff : i_ee_sw_sk};
                o_prdb_oe  <= {{5{i_prdb_drive}}, 3'h3};
            end else begin
                o_prdb_out <= i_prdb_out;
                o_prdb_oe  <= {8{i_prdb_drive}};
            end
            o_eeprom_chip_select <= (st_ff == `SBPF_ST_SHIFT)
                                  | (ee_pins & i_ee_sw_cs);
            o_shift_busy_out <= (st_ff == `SBPF_ST_SHIFT);
            o_shift_busy_oe  <= (st_ff == `SBPF_ST_SHIFT);
            if (st_ff == `SBPF_ST_SHIFT) begin
                o_ee_checksum_err <= 1'b0;
                o_eeprom_reload_bit_done    <= 1'b0;
            end else if (st_ff == `SBPF_ST_DONE) begin
                o_eeprom_reload_bit_done <= 1'b1;
            end
            // Pin held low while idle means no EEPROM present
            if ((st_ff == `SBPF_ST_IDLE) & ~i_shift_busy) begin
                o_ee_checksum_err <= 1'b1;
            end
            if (~arch_seen_ff) begin
                arch_seen_ff     <= 1'b1;
                o_bus_slave_mode <= ~i_slave_architecture_select;
            end
            o_pio_mode <= i_csr2[`SBPF_CSR2_ARCHITECTURE_SELECT_BIT_BIT];
            // PIO mode (Config2 bit 13) blocks both shared-memory strobes, whatever the match pin
            o_shmem_read  <= ~i_csr2[`SBPF_CSR2_ARCHITECTURE_SELECT_BIT_BIT]
                           & ~i_shared_memory_match_n
                           & ~i_host_memory_read_strobe_n;
            o_shmem_write <= ~i_csr2[`SBPF_CSR2_ARCHITECTURE_SELECT_BIT_BIT]
                           & ~i_shared_memory_match_n
                           & ~i_host_memory_write_strobe_n;
            o_sram_select_or_irq_line <= i_flash_boot
                ? i_shared_memory_match_n : i_irq12;
            // SRAM-only strobe is blocked in PIO mode; with flash fitted it stays live in PIO mode as the global strobe
            o_sram_or_global_write_strobe_n <= ~(~i_shared_memory_match_n
                & ~i_host_memory_write_strobe_n
                & (i_flash_fitted | ~i_csr2[`SBPF_CSR2_ARCHITECTURE_SELECT_BIT_BIT]));
            o_sram_output_enable_n <= ~(~i_shared_memory_match_n
                & ~i_host_memory_read_strobe_n);
            o_tdo     <= i_tap_tdo;
            o_tdo_oe  <= i_tap_shifting;
            o_tdi_eff <= i_tdi_oe ? i_tdi_in : 1'b1;
            o_tms_eff <= i_tms_oe ? i_tms_in : 1'b1;
        end
    end

endmodule

`default_nettype wire

/* testbench/sbpf_ee_model.sv */
// Behavioural serial EEPROM that answers the load reads
`timescale 1ns/1ps
`default_nettype none
module sbpf_ee_model #(
    parameter logic [127:0] P_IMAGE = 128'h0
) (
    input  wire logic i_cs,
    input  wire logic i_sk,
    output var  logic o_do
);
    logic [6:0] idx_ff = 7'h7f;
    // Deselect rewinds; advance on the falling edge so the bit is stable
    // at the sampling edge
    always @(negedge i_sk or negedge i_cs) begin
        if (!i_cs) idx_ff <= 7'h7f;
        else idx_ff <= idx_ff - 7'h01;
    end
    // Deselected: show the inverse so a stale bit never looks valid
    always @* o_do = i_cs ? P_IMAGE[idx_ff] : ~P_IMAGE[idx_ff];
endmodule
`default_nettype wire

/* testbench/sbpf_top_assertions.sv */
// Port-level assertions for the pin-function block
`timescale 1ns/1ps
`default_nettype none
module sbpf_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_sleep_n,
    input wire logic [15:0] i_csr2,
    input wire logic [15:0] i_csr3,
    input wire logic        i_ext_addr_detect_mode,
    input wire logic        i_internal_reject,
    input wire logic        i_external_reject_input,
    input wire logic        i_tap_shifting,
    input wire logic        i_tdi_oe,
    input wire logic        o_frame_reject,
    input wire logic [7:0]  o_prdb_oe,
    input wire logic        o_eeprom_chip_select,
    input wire logic        o_shift_busy_out,
    input wire logic        o_pio_mode,
    input wire logic        o_tdo_oe,
    input wire logic        o_tdi_eff
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst || !i_sleep_n);
    logic        live_ff;
    logic [10:0] busy_cnt_ff;
    // Outputs sampled while live_ff is high were launched out of reset
    always @(posedge i_ref_clk or posedge i_rst or negedge i_sleep_n) begin
        if (i_rst || !i_sleep_n) begin
            live_ff <= 1'b0;
            busy_cnt_ff <= 11'h000;
        end else begin
            live_ff <= 1'b1;
            busy_cnt_ff <= o_shift_busy_out ? busy_cnt_ff + 11'h001 : 11'h000;
        end
    end
    a_reject_or: assert property (live_ff && $past(i_ext_addr_detect_mode)
        |-> o_frame_reject == ($past(i_internal_reject)
        | $past(i_external_reject_input))) else $error("reject not OR");
    a_eeprom_data_out_input: assert property (live_ff && $past(i_csr3[4])
        |-> !o_prdb_oe[2]) else $error("eeprom data out pin driven");
    a_busy_with_cs: assert property (o_shift_busy_out
        |-> o_eeprom_chip_select) else $error("load without chip select");
    a_load_bounded: assert property (busy_cnt_ff < 11'h5dc)
        else $error("shift busy held too long");
    a_load_at_wake: assert property (live_ff && !$past(live_ff)
        |-> o_shift_busy_out && o_eeprom_chip_select) else $error("no load");
    a_arch_select: assert property (live_ff
        |-> o_pio_mode == $past(i_csr2[13])) else $error("arch select wrong");
    a_tdo_quiet: assert property (live_ff && !$past(i_tap_shifting)
        |-> !o_tdo_oe) else $error("test output driven while idle");
    a_tdi_default: assert property (live_ff && !$past(i_tdi_oe)
        |-> o_tdi_eff) else $error("floating test input not high");
    cover property (live_ff && o_frame_reject);
    cover property ($fell(o_shift_busy_out));
    cover property (o_pio_mode);
endmodule
bind sbpf_top sbpf_chk u_sbpf_chk (.*);
`default_nettype wire

/* testbench/tb_sbpf_top.sv */
// Self-checking bench for the pin-function block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_sbpf_top;
    localparam logic [127:0] IMG = 128'h0123456789abcdeffedcba9876543210;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_sleep_n = 1'b1, pull = 1'b1;
    logic i_ext_addr_detect_mode = 1'b0, i_flash_boot = 1'b0;
    logic i_flash_fitted = 1'b0, i_link_status = 1'b0, i_irq12 = 1'b0;
    logic i_start_frame_byte_delimiter = 1'b0, i_serial_receive_data = 1'b0;
    logic i_serial_receive_clock = 1'b0, i_internal_reject = 1'b0;
    logic i_external_reject_input = 1'b0, i_ee_sw_cs = 1'b0, i_ee_sw_sk = 1'b0;
    logic i_ee_sw_di = 1'b0, i_tap_shifting = 1'b0, i_tap_tdo = 1'b0;
    logic i_shared_memory_match_n = 1'b1, i_host_memory_read_strobe_n = 1'b1;
    logic i_host_memory_write_strobe_n = 1'b1, i_tdi_in = 1'b0;
    logic i_tdi_oe = 1'b0, i_tms_in = 1'b0, i_tms_oe = 1'b0;
    logic i_prdb_drive = 1'b0, i_slave_architecture_select = 1'b0;
    logic [15:0] i_csr2 = 16'h0000, i_csr3 = 16'h0000;
    logic [7:0] i_prdb_out = 8'h00, o_prdb_out, o_prdb_oe;
    logic [3:0] i_led_status = 4'h0, o_indicator_outputs_n;
    logic [2:0] i_ee_raddr = 3'h0;
    logic [15:0] o_ee_rdata;
    wire logic i_shift_busy, ee_do;
    wire logic [7:0] i_prdb_in;
    logic o_frame_reject, o_eeprom_chip_select, o_shift_busy_out;
    logic o_shift_busy_oe, o_ee_checksum_err, o_eeprom_reload_bit_done, o_tdo;
    logic o_bus_slave_mode, o_pio_mode, o_shmem_read, o_shmem_write;
    logic o_sram_select_or_irq_line, o_sram_or_global_write_strobe_n;
    logic o_sram_output_enable_n, o_tdo_oe, o_tdi_eff, o_tms_eff;
    int error_cnt = 0, n_checks = 0;
    sbpf_top u_sbpf_top (.*);
    sbpf_ee_model #(.P_IMAGE(IMG)) u_sbpf_ee_model (
        .i_cs(o_eeprom_chip_select), .i_sk(o_prdb_out[0]), .o_do(ee_do));
    assign i_prdb_in = {5'h00, ee_do, o_prdb_out[1:0]};
    // Board pull-up on shift busy unless a scenario pulls it down
    assign i_shift_busy = o_shift_busy_oe ? o_shift_busy_out : pull;
    initial forever #5 i_ref_clk = ~i_ref_clk;
    task cy(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task load_chk;
        int k;
        cy(3);
        `CHK("busy_cs", 2'b11, {o_shift_busy_out, o_eeprom_chip_select})
        `CHK("busy_oe", 1'b1, o_shift_busy_oe)
        for (k = 0; k < 3000 && o_shift_busy_out !== 1'b0; k++) cy(1);
        `CHK("busy_end", 1'b0, o_shift_busy_out)
        `CHK("end", 3'b010, {o_eeprom_chip_select, o_eeprom_reload_bit_done, o_ee_checksum_err})
        for (k = 0; k < 8; k++) begin
            @(posedge i_ref_clk);
            i_ee_raddr <= k[2:0];
            cy(1);
            `CHK("word", IMG[127-16*k -: 16], o_ee_rdata)
        end
    endtask
    task t_leds;
        @(posedge i_ref_clk);
        i_led_status <= 4'h5;
        cy(1);
        `CHK("led", 4'ha, o_indicator_outputs_n)
        @(posedge i_ref_clk);
        i_ext_addr_detect_mode <= 1'b1;
        i_start_frame_byte_delimiter <= 1'b1;
        i_serial_receive_clock <= 1'b1;
        cy(1);
        `CHK("external_address_detect_mode", 4'h5, o_indicator_outputs_n)
        for (int k = 0; k < 4; k++) begin
            @(posedge i_ref_clk);
            {i_internal_reject, i_external_reject_input} <= k[1:0];
            cy(1);
            `CHK("reject", |k[1:0], o_frame_reject)
        end
        @(posedge i_ref_clk);
        i_ext_addr_detect_mode <= 1'b0;
    endtask
    task t_pins;
        @(posedge i_ref_clk);
        i_csr3[4] <= 1'b1;
        i_ee_sw_cs <= 1'b1;
        i_ee_sw_sk <= 1'b1;
        cy(1);
        `CHK("ee", 6'h2d, {o_eeprom_chip_select, o_prdb_oe[2:0], o_prdb_out[1:0]})
        @(posedge i_ref_clk);
        i_csr3[4] <= 1'b0;
        i_ee_sw_cs <= 1'b0;
        i_shared_memory_match_n <= 1'b0;
        i_host_memory_write_strobe_n <= 1'b0;
        i_flash_fitted <= 1'b1;
        cy(1);
        `CHK("prdb", 9'h000, {o_eeprom_chip_select, o_prdb_oe})
        `CHK("wr", 5'h12, {o_bus_slave_mode, o_pio_mode, o_shmem_read, o_shmem_write, o_sram_or_global_write_strobe_n})
        @(posedge i_ref_clk);
        i_host_memory_write_strobe_n <= 1'b1;
        i_host_memory_read_strobe_n <= 1'b0;
        i_flash_fitted <= 1'b0;
        cy(1);
        `CHK("rd", 3'h4, {o_shmem_read, o_shmem_write, o_sram_output_enable_n})
        @(posedge i_ref_clk);
        i_csr2[13] <= 1'b1;
        i_shared_memory_match_n <= 1'b1;
        i_host_memory_read_strobe_n <= 1'b1;
        i_irq12 <= 1'b1;
        cy(1);
        `CHK("pio", 4'hb, {o_pio_mode, o_shmem_read, o_sram_output_enable_n, o_sram_select_or_irq_line})
    endtask
    task t_jtag;
        @(posedge i_ref_clk);
        i_csr2[13] <= 1'b0;
        // Test data input driven and mode select left open, then the reverse
        i_tap_shifting <= 1'b1;
        i_tap_tdo <= 1'b1;
        i_tdi_oe <= 1'b1;
        i_flash_boot <= 1'b1;
        i_shared_memory_match_n <= 1'b0;
        cy(1);
        `CHK("tap", 3'h5, {o_tdo_oe, o_tdi_eff, o_tms_eff})
        `CHK("tdo", 1'b1, o_tdo)
        `CHK("srcs", 1'b0, o_sram_select_or_irq_line)
        @(posedge i_ref_clk);
        i_tap_shifting <= 1'b0;
        i_tdi_oe <= 1'b0;
        i_tms_oe <= 1'b1;
        i_flash_boot <= 1'b0;
        i_shared_memory_match_n <= 1'b1;
        cy(1);
        `CHK("tap_idle", 3'h2, {o_tdo_oe, o_tdi_eff, o_tms_eff})
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        load_chk;
        t_leds;
        t_pins;
        t_jtag;
        @(posedge i_ref_clk);
        pull <= 1'b0;
        cy(2);
        `CHK("ck_err", 1'b1, o_ee_checksum_err)
        @(posedge i_ref_clk);
        pull <= 1'b1;
        i_csr3[14] <= 1'b1;
        load_chk;
        @(posedge i_ref_clk);
        i_led_status <= 4'hf;
        i_sleep_n <= 1'b0;
        i_csr2[13] <= 1'b1;
        i_csr3[14] <= 1'b0;
        cy(2);
        `CHK("sleep", 6'h3c, {o_indicator_outputs_n, o_eeprom_chip_select, o_pio_mode})
        @(posedge i_ref_clk);
        // Settle wait after wake scaled down to keep the run short
        i_sleep_n <= 1'b1;
        i_csr2[13] <= 1'b0;
        load_chk;
        wrap_up;
    end
    initial begin
        #100000;
        error_cnt++;
        wrap_up;
    end
endmodule
`default_nettype wire
